// >>> design/cgosd_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the clock block
// Assumes: 25 MHz bus clock, byte addressed register map
// Notes: Definitions only
`ifndef CGOSD_CONSTS_SVH
`define CGOSD_CONSTS_SVH

// Register byte offsets
`define CGOSD_CTRL0_OFF 5'h00
`define CGOSD_CTRL1_OFF 5'h04
`define CGOSD_CTRL3_OFF 5'h08
`define CGOSD_OCD_OFF 5'h0c
`define CGOSD_PROT_OFF 5'h10

// System clock control 0 fields
`define CGOSD_C0_WSTOP_LO 1
`define CGOSD_C0_WSTOP_HI 2
`define CGOSD_C0_MAIN_STOP 5
`define CGOSD_C0_DIV8 6
`define CGOSD_CTRL0_RST 8'h20

// System clock control 1 fields
`define CGOSD_C1_PIN_FN 3
`define CGOSD_C1_LOW_STOP 4
`define CGOSD_C1_DIV_LO 6
`define CGOSD_C1_DIV_HI 7
`define CGOSD_CTRL1_RST 8'h00

// System clock control 3 and protect fields
`define CGOSD_C3_NODIV 5
`define CGOSD_PROT_UNLOCK 0

// Stop detection control fields
`define CGOSD_OCD_DET_EN 0
`define CGOSD_OCD_IRQ_EN 1
`define CGOSD_OCD_SEL 2
`define CGOSD_OCD_MON 3
`define CGOSD_OCD_RST 8'h04

// Timing: main clock declared dead after this long without an edge
`define CGOSD_CLK_PERIOD_NS 40
`define CGOSD_STOP_TIMEOUT_NS 2000
`define CGOSD_STOP_TIMEOUT_CYC \
    ((`CGOSD_STOP_TIMEOUT_NS + `CGOSD_CLK_PERIOD_NS - 1) / `CGOSD_CLK_PERIOD_NS)
`define CGOSD_SLOW_DIV 128

`endif

// >>> design/cgosd_pkg.sv
// Purpose: Types shared by the clock generation and stop detection block
// Assumes: Constants live in cgosd_consts.svh
// Notes: Nothing here is imported; users write cgosd_pkg::name
package cgosd_pkg;

    // CPU clock division modes
    typedef enum logic [2:0] {
        CGOSD_DIV1 = 3'b000,
        CGOSD_DIV2 = 3'b001,
        CGOSD_DIV4 = 3'b010,
        CGOSD_DIV8 = 3'b011,
        CGOSD_DIV16 = 3'b100
    } cgosd_div_type;

    // Peripheral clock ticks f1..f32
    typedef struct packed {
        logic f1;
        logic f2;
        logic f4;
        logic f8;
        logic f32;
    } cgosd_periph_type;

    // Oscillator stop detection control bits
    typedef struct packed {
        logic main_clk_monitor;
        logic internal_osc_select;
        logic stop_detect_irq_enable;
        logic stop_detect_enable;
    } cgosd_ocd_type;

endpackage

// >>> design/cgosd_top.sv
// Purpose: Clock source select, CPU and peripheral dividers, main oscillator stop detection
// Assumes: Oscillator pins sampled on clock_i; derived clocks leave as one-cycle ticks
// Notes: Avalon-MM slave with waitrequest; one wait cycle per access
//
// Behaviour
// - Detection register: detect enable b0, irq enable b1, select b2, monitor b3.
// - Main stop with both enables set forces internal oscillator selection.
// - While monitor reads 1, writing 0 to select is ignored.
// - Select at 1 forces the low-speed oscillator stop bit to 0.
// - Monitor only meaningful with detection enabled; zero when enables are 00.
// - Stop while main sources CPU: select, monitor, oscillator on, interrupt request.
// - Main oscillator stopped during and after reset until software enables it.
// - With oscillator pins selected, clearing main stop starts oscillation.
// - After reset CPU clock is internal oscillator undivided.
// - CPU clock is system clock divided by 1, 2, 4, 8 or 16.
// - Division field 00/01/10/11 gives 1/2/4/16 while divide-by-8 is off.
// - Stop mode entry sets the divide-by-8 bit.
// - Peripheral clocks are system clock divided by 1, 2, 4, 8, 32.
// - Wait mode with nonzero peripheral-stop field stops peripheral clocks.
// - Internal oscillator peripheral clock keeps running in wait mode.
// - Voltage detector clock from low oscillator, only while its stop bit is 0.
// - Slow capture clock is voltage detector clock divided by 128.
// - Watchdog clock from low oscillator while count source protection is on.
// - Stop interrupt identified by monitor 1, or enables 11 with select 1.
`timescale 1ns/100ps
`include "cgosd_consts.svh"

module cgosd_top (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic main_osc_in_i,
    input wire logic low_osc_in_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic count_source_protect_i,
    output logic main_osc_en_o,
    output logic low_osc_en_o,
    output logic osc_pin_function_o,
    output logic cpu_clk_tick_o,
    output cgosd_pkg::cgosd_periph_type periph_clk_o,
    output logic int_osc_periph_clk_o,
    output logic volt_detect_clk_o,
    output logic slow_capture_clk_o,
    output logic watchdog_clk_o,
    output logic stop_irq_o
);

    localparam int TIMEOUT = `CGOSD_STOP_TIMEOUT_CYC;
    localparam logic [5:0] TIMEOUT_CNT = 6'(TIMEOUT);

    // Control registers
    logic [1:0] wait_periph_stop_q;
    logic main_osc_stop_q;
    logic div8_select_q;
    logic osc_pin_function_q;
    logic low_osc_stop_q;
    logic [1:0] cpu_div_field_q;
    logic wait_exit_nodiv_q;
    logic unlock_q;
    cgosd_pkg::cgosd_ocd_type ocd_q;

    // Bus handshake
    logic wait_q;
    logic [31:0] rdata_q;
    logic acc_w;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    // Pin synchronisers: stage 1 feeds only stage 2
    logic main_s1_q, main_s2_q, main_s3_q;
    logic low_s1_q, low_s2_q, low_s3_q;
    logic main_edge, low_edge, sys_tick;

    // Stop detection
    logic [5:0] dead_cnt_q;
    logic dead;
    logic dead_prev_q;
    logic det_event;
    logic both_en;

    // Dividers
    cgosd_pkg::cgosd_div_type div_req, div_cur_q;
    logic [3:0] cpu_cnt_q;
    logic [3:0] cpu_last;
    logic [4:0] per_cnt_q;
    logic [6:0] slow_cnt_q;
    logic periph_run;
    logic stop_prev_q, wait_prev_q;

    assign acc_w = avs_write_i && !wait_q && avs_byteenable_i[0];
    assign wbyte = avs_writedata_i[7:0];

    // Two-flop synchronisers plus one stage for edge detection
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            main_s1_q <= 1'b0;
            main_s2_q <= 1'b0;
            main_s3_q <= 1'b0;
            low_s1_q <= 1'b0;
            low_s2_q <= 1'b0;
            low_s3_q <= 1'b0;
        end else begin
            main_s1_q <= main_osc_in_i;
            main_s2_q <= main_s1_q;
            main_s3_q <= main_s2_q;
            low_s1_q <= low_osc_in_i;
            low_s2_q <= low_s1_q;
            low_s3_q <= low_s2_q;
        end
    end

    assign main_edge = main_s2_q && !main_s3_q;
    assign low_edge = low_s2_q && !low_s3_q;
    // Whole oscillator edges only, so a source switch never cuts a pulse
    assign sys_tick = ocd_q.internal_osc_select ? low_edge : main_edge;

    // Main clock watchdog: saturating count of cycles since the last edge
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dead_cnt_q <= 6'h00;
            dead_prev_q <= 1'b0;
        end else begin
            if (main_edge) begin
                dead_cnt_q <= 6'h00;
            end else if (dead_cnt_q != TIMEOUT_CNT) begin
                dead_cnt_q <= dead_cnt_q + 6'h01;
            end
            dead_prev_q <= dead;
        end
    end

    assign dead = (dead_cnt_q == TIMEOUT_CNT);
    assign both_en = ocd_q.stop_detect_enable && ocd_q.stop_detect_irq_enable;
    assign det_event = dead && !dead_prev_q && both_en;

    // Detection register; hardware set beats a software clear
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ocd_q <= cgosd_pkg::cgosd_ocd_type'(4'(`CGOSD_OCD_RST));
        end else begin
            if (acc_w && avs_address_i == `CGOSD_OCD_OFF && unlock_q) begin
                ocd_q.stop_detect_enable <= wbyte[`CGOSD_OCD_DET_EN];
                ocd_q.stop_detect_irq_enable <= wbyte[`CGOSD_OCD_IRQ_EN];
            end
            if (det_event) begin
                ocd_q.internal_osc_select <= 1'b1;
            end else if (acc_w && avs_address_i == `CGOSD_OCD_OFF && unlock_q) begin
                if (wbyte[`CGOSD_OCD_SEL] || !ocd_q.main_clk_monitor) begin
                    ocd_q.internal_osc_select <= wbyte[`CGOSD_OCD_SEL];
                end
            end
            // Monitor follows the dead detector only with detection on
            ocd_q.main_clk_monitor <= dead && ocd_q.stop_detect_enable;
        end
    end

    // Interrupt request pulse; shares a vector, so the sources stay readable
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stop_irq_o <= 1'b0;
        end else begin
            stop_irq_o <= det_event && !ocd_q.internal_osc_select;
        end
    end

    // Write protection unlock
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            unlock_q <= 1'b0;
        end else if (acc_w && avs_address_i == `CGOSD_PROT_OFF) begin
            unlock_q <= wbyte[`CGOSD_PROT_UNLOCK];
        end
    end

    // Clock control registers, writable only when unlocked
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_periph_stop_q <= 2'b00;
            main_osc_stop_q <= 1'b1;
            div8_select_q <= 1'b0;
            osc_pin_function_q <= 1'b0;
            cpu_div_field_q <= 2'b00;
            wait_exit_nodiv_q <= 1'b0;
        end else begin
            if (acc_w && unlock_q && avs_address_i == `CGOSD_CTRL0_OFF) begin
                wait_periph_stop_q <= wbyte[`CGOSD_C0_WSTOP_HI:`CGOSD_C0_WSTOP_LO];
                main_osc_stop_q <= wbyte[`CGOSD_C0_MAIN_STOP];
                div8_select_q <= wbyte[`CGOSD_C0_DIV8];
            end
            if (acc_w && unlock_q && avs_address_i == `CGOSD_CTRL1_OFF) begin
                // Pin function cannot return to port mode once set
                osc_pin_function_q <= osc_pin_function_q || wbyte[`CGOSD_C1_PIN_FN];
                cpu_div_field_q <= wbyte[`CGOSD_C1_DIV_HI:`CGOSD_C1_DIV_LO];
            end
            if (acc_w && unlock_q && avs_address_i == `CGOSD_CTRL3_OFF) begin
                wait_exit_nodiv_q <= wbyte[`CGOSD_C3_NODIV];
            end
            // Power mode entries override software in the same cycle
            if (wait_mode_i && !wait_prev_q && wait_exit_nodiv_q) begin
                div8_select_q <= 1'b0;
                cpu_div_field_q <= 2'b00;
            end
            if (stop_mode_i && !stop_prev_q) begin
                div8_select_q <= 1'b1;
            end
        end
    end

    // Low-speed oscillator stop bit, held at 0 while internal select is 1
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_osc_stop_q <= 1'b0;
        end else if (ocd_q.internal_osc_select || det_event) begin
            low_osc_stop_q <= 1'b0;
        end else if (acc_w && unlock_q && avs_address_i == `CGOSD_CTRL1_OFF) begin
            low_osc_stop_q <= wbyte[`CGOSD_C1_LOW_STOP];
        end
    end

    // Mode entry edge detectors
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stop_prev_q <= 1'b0;
            wait_prev_q <= 1'b0;
        end else begin
            stop_prev_q <= stop_mode_i;
            wait_prev_q <= wait_mode_i;
        end
    end

    // Requested division ratio
    always_comb begin
        if (div8_select_q) begin
            div_req = cgosd_pkg::CGOSD_DIV8;
        end else begin
            unique case (cpu_div_field_q)
                2'b00: div_req = cgosd_pkg::CGOSD_DIV1;
                2'b01: div_req = cgosd_pkg::CGOSD_DIV2;
                2'b10: div_req = cgosd_pkg::CGOSD_DIV4;
                2'b11: div_req = cgosd_pkg::CGOSD_DIV16;
            endcase
        end
    end

    // Last count value of the running ratio
    always_comb begin
        unique case (div_cur_q)
            cgosd_pkg::CGOSD_DIV1: cpu_last = 4'h0;
            cgosd_pkg::CGOSD_DIV2: cpu_last = 4'h1;
            cgosd_pkg::CGOSD_DIV4: cpu_last = 4'h3;
            cgosd_pkg::CGOSD_DIV8: cpu_last = 4'h7;
            cgosd_pkg::CGOSD_DIV16: cpu_last = 4'hf;
            default: cpu_last = 4'h0;
        endcase
    end

    // CPU clock divider; new ratio taken only at a period boundary
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cpu_cnt_q <= 4'h0;
            div_cur_q <= cgosd_pkg::CGOSD_DIV1;
            cpu_clk_tick_o <= 1'b0;
        end else begin
            cpu_clk_tick_o <= 1'b0;
            if (sys_tick) begin
                if (cpu_cnt_q == cpu_last) begin
                    cpu_cnt_q <= 4'h0;
                    div_cur_q <= div_req;
                    cpu_clk_tick_o <= !wait_mode_i && !stop_mode_i;
                end else begin
                    cpu_cnt_q <= cpu_cnt_q + 4'h1;
                end
            end
        end
    end

    assign periph_run = !stop_mode_i && !(wait_mode_i && wait_periph_stop_q != 2'b00);

    // Peripheral clock ticks f1..f32
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            per_cnt_q <= 5'h00;
            periph_clk_o <= '0;
        end else begin
            if (sys_tick) begin
                per_cnt_q <= per_cnt_q + 5'h01;
            end
            periph_clk_o.f1 <= sys_tick && periph_run;
            periph_clk_o.f2 <= sys_tick && periph_run && per_cnt_q[0];
            periph_clk_o.f4 <= sys_tick && periph_run && (&per_cnt_q[1:0]);
            periph_clk_o.f8 <= sys_tick && periph_run && (&per_cnt_q[2:0]);
            periph_clk_o.f32 <= sys_tick && periph_run && (&per_cnt_q);
        end
    end

    // Oscillator derived clocks; none of them stop in wait mode
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            slow_cnt_q <= 7'h00;
            int_osc_periph_clk_o <= 1'b0;
            volt_detect_clk_o <= 1'b0;
            slow_capture_clk_o <= 1'b0;
            watchdog_clk_o <= 1'b0;
        end else begin
            int_osc_periph_clk_o <= low_edge && !low_osc_stop_q && !stop_mode_i;
            volt_detect_clk_o <= low_edge && !low_osc_stop_q && !stop_mode_i;
            if (low_edge && !low_osc_stop_q && !stop_mode_i) begin
                slow_cnt_q <= slow_cnt_q + 7'h01;
            end
            slow_capture_clk_o <= low_edge && !low_osc_stop_q && !stop_mode_i
                && (slow_cnt_q == 7'(`CGOSD_SLOW_DIV - 1));
            watchdog_clk_o <= low_edge && count_source_protect_i;
        end
    end

    // Oscillator enables and pin function
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            main_osc_en_o <= 1'b0;
            low_osc_en_o <= 1'b0;
            osc_pin_function_o <= 1'b0;
        end else begin
            main_osc_en_o <= !main_osc_stop_q && osc_pin_function_q && !stop_mode_i;
            low_osc_en_o <= (!low_osc_stop_q && !stop_mode_i) || count_source_protect_i;
            osc_pin_function_o <= osc_pin_function_q;
        end
    end

    // Read mux
    always_comb begin
        unique case (avs_address_i)
            `CGOSD_CTRL0_OFF: rbyte = {1'b0, div8_select_q, main_osc_stop_q, 2'b00,
                                       wait_periph_stop_q, 1'b0};
            `CGOSD_CTRL1_OFF: rbyte = {cpu_div_field_q, 1'b0, low_osc_stop_q,
                                       osc_pin_function_q, 3'b000};
            `CGOSD_CTRL3_OFF: rbyte = {2'b00, wait_exit_nodiv_q, 5'h00};
            `CGOSD_OCD_OFF: rbyte = {4'h0, ocd_q};
            `CGOSD_PROT_OFF: rbyte = {7'h00, unlock_q};
            default: rbyte = 8'h00;
        endcase
    end

    // Bus answer: waitrequest drops one cycle after the request, then rises
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            if (wait_q && (avs_read_i || avs_write_i)) begin
                wait_q <= 1'b0;
                rdata_q <= {24'h000000, rbyte};
            end else begin
                wait_q <= 1'b1;
            end
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;

endmodule

// >>> tb/cgosd_monitor.sv
// Purpose: Port-level checks on bus timing, derived ticks and stop detection
// Assumes: One clock domain, reset active low
// Notes: Bound to cgosd_top at the foot of this file
`timescale 1ns/100ps
module cgosd_monitor (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic stop_mode_i,
    input wire logic count_source_protect_i,
    input wire logic main_osc_en_o,
    input wire logic low_osc_en_o,
    input wire logic cpu_clk_tick_o,
    input wire cgosd_pkg::cgosd_periph_type periph_clk_o,
    input wire logic volt_detect_clk_o,
    input wire logic slow_capture_clk_o,
    input wire logic watchdog_clk_o,
    input wire logic stop_irq_o
);
    logic [7:0] vcnt_q, vcnt_d;
    logic wrote_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    // Volt ticks since the last slow tick; a tick in the slow cycle closes the old span
    assign vcnt_d = slow_capture_clk_o ? 8'h00 : vcnt_q + {7'h00, volt_detect_clk_o};
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vcnt_q <= 8'h00;
            wrote_q <= 1'h0;
        end else begin
            vcnt_q <= vcnt_d;
            wrote_q <= wrote_q | (avs_write_i & ~avs_waitrequest_o);
        end
    end

    // Assertions, each tying an output to its cause
    property p_bus_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o; endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("access not answered");
    property p_bus_gap; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    a_bus_gap: assert property (p_bus_gap) else $error("wait low twice");
    property p_rdata_hi; !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000; endproperty
    a_rdata_hi: assert property (p_rdata_hi) else $error("read upper bits set");
    property p_irq_pulse; stop_irq_o |=> !stop_irq_o; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a cycle");
    property p_irq_low; stop_irq_o && !stop_mode_i |-> ##[0:1] low_osc_en_o; endproperty
    a_irq_low: assert property (p_irq_low) else $error("low osc off after stop");
    property p_main_rst; !wrote_q |-> !main_osc_en_o; endproperty
    a_main_rst: assert property (p_main_rst) else $error("main osc runs unasked");
    property p_vd_gate; volt_detect_clk_o && !stop_mode_i
        |-> low_osc_en_o || $past(low_osc_en_o); endproperty
    a_vd_gate: assert property (p_vd_gate) else $error("volt tick with osc off");
    property p_wdt_gate; watchdog_clk_o
        |-> count_source_protect_i || $past(count_source_protect_i); endproperty
    a_wdt_gate: assert property (p_wdt_gate) else $error("watchdog tick unprotected");
    property p_f32_align; periph_clk_o.f32 |-> &periph_clk_o[4:1]; endproperty
    a_f32_align: assert property (p_f32_align) else $error("f32 off the f1 grid");
    property p_slow_div; slow_capture_clk_o |-> vcnt_q == 8'h7f || vcnt_q == 8'h80; endproperty
    a_slow_div: assert property (p_slow_div) else $error("slow tick off by count");
    property p_slow_max; vcnt_q <= 8'h80; endproperty
    a_slow_max: assert property (p_slow_max) else $error("slow tick missing");

    // Main scenarios reached
    c_irq: cover property (stop_irq_o);
    c_slow: cover property (slow_capture_clk_o);
    c_wdt: cover property (watchdog_clk_o);
    c_cpu: cover property (cpu_clk_tick_o);
endmodule

bind cgosd_top cgosd_monitor u_mon (
    .clock_i, .resetn_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
    .stop_mode_i, .count_source_protect_i, .main_osc_en_o, .low_osc_en_o, .cpu_clk_tick_o,
    .periph_clk_o, .volt_detect_clk_o, .slow_capture_clk_o, .watchdog_clk_o, .stop_irq_o
);

// >>> tb/cgosd_osc_model.sv
// Purpose: Main resonator and low-speed oscillator seen at the block's pins
// Assumes: Half periods well above the two-cycle edge detector limit
// Notes: A stopped oscillator holds its level, as a dead resonator does
`timescale 1ns/100ps
module cgosd_osc_model #(
    parameter int MAIN_HALF_NS = 110,
    parameter int LOW_HALF_NS = 130
) (
    input wire logic main_en_i,
    input wire logic main_kill_i,
    input wire logic low_en_i,
    output logic main_osc_o,
    output logic low_osc_o
);
    // 4.5 MHz resonator, above the detection floor
    // One resonator only, never swapped for an external clock
    initial begin
        main_osc_o = 1'h0;
        forever begin
            #(MAIN_HALF_NS);
            if (main_en_i && !main_kill_i) main_osc_o = !main_osc_o;
        end
    end
    // Low oscillator runs while enabled or held by watchdog protection
    initial begin
        low_osc_o = 1'h0;
        forever begin
            #(LOW_HALF_NS);
            if (low_en_i) low_osc_o = !low_osc_o;
        end
    end
endmodule

// >>> tb/clock_gen_osc_stop_detect_test.sv
// Purpose: Self-checking bench for bus, dividers, gating and stop detection
// Assumes: Oscillators come from the partner model
// Notes: Read results retire through an expectation queue
`timescale 1ns/100ps
module clock_gen_osc_stop_detect_test;
    logic clock_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [4:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0] avs_byteenable_i;
    logic main_osc_in_i, low_osc_in_i, wait_mode_i, stop_mode_i, count_source_protect_i;
    logic main_osc_en_o, low_osc_en_o, osc_pin_function_o, cpu_clk_tick_o, main_kill;
    cgosd_pkg::cgosd_periph_type periph_clk_o;
    logic int_osc_periph_clk_o, volt_detect_clk_o, slow_capture_clk_o, watchdog_clk_o, stop_irq_o;
    logic [7:0] tk;
    logic [31:0] exp_q[$];
    int cnt[8] = '{default: 0};
    int miscompares = 0;
    int check_count = 0;

    cgosd_top uut (.clock_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .main_osc_in_i, .low_osc_in_i, .wait_mode_i, .stop_mode_i, .count_source_protect_i,
        .main_osc_en_o, .low_osc_en_o, .osc_pin_function_o, .cpu_clk_tick_o, .periph_clk_o,
        .int_osc_periph_clk_o, .volt_detect_clk_o, .slow_capture_clk_o, .watchdog_clk_o,
        .stop_irq_o);
    cgosd_osc_model osc (.main_en_i(main_osc_en_o), .main_kill_i(main_kill),
        .low_en_i(low_osc_en_o | count_source_protect_i), .main_osc_o(main_osc_in_i),
        .low_osc_o(low_osc_in_i));

    initial begin
        clock_i = 1'h0;
        forever #20 clock_i = ~clock_i;
    end

    // Tick tallies: 0 cpu, 1 f1, 2 f32, 3 int osc, 4 volt, 5 slow, 6 watchdog, 7 irq
    assign tk = {stop_irq_o, watchdog_clk_o, slow_capture_clk_o, volt_detect_clk_o,
        int_osc_periph_clk_o, periph_clk_o.f32, periph_clk_o.f1, cpu_clk_tick_o};
    always @(posedge clock_i) begin
        for (int k = 0; k < 8; k++) cnt[k] <= cnt[k] + int'(tk[k] === 1'h1);
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Each completed read retires the oldest expectation
    always @(posedge clock_i) begin
        if (avs_read_i === 1'h1 && avs_waitrequest_o === 1'h0 && exp_q.size() > 0) begin
            check(avs_readdata_o, exp_q.pop_front());
        end
    end

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h000000, d};
        avs_read_i <= ~wr;
        avs_write_i <= wr;
        do @(posedge clock_i); while (avs_waitrequest_o !== 1'h0);
        avs_read_i <= 1'h0;
        avs_write_i <= 1'h0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        bus(1'h0, a, 8'h00);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'h1, a, d);
    endtask
    task automatic bump(input int w);
        int v;
        v = cnt[w];
        do @(posedge clock_i); while (cnt[w] == v);
    endtask

    // Ticks of m within one period of w, after the ratio has settled
    task automatic per(input int w, input int m, input int n);
        int s;
        repeat (2) bump(w);
        s = cnt[m];
        bump(w);
        check(cnt[m] - s, n);
    endtask

    task automatic done(input string t);
        $display("done %s", t);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #3000000;
        miscompares++;
        finish_test();
    end

    initial begin
        int s[8];
        void'($urandom(90));
        {resetn_i, avs_read_i, avs_write_i, wait_mode_i, stop_mode_i} = 5'h00;
        {count_source_protect_i, main_kill} = 2'h0;
        avs_address_i = 5'h00;
        avs_writedata_i = 32'h00000000;
        avs_byteenable_i = 4'hf;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'h1;
        // Reset state and undivided internal clock
        check(main_osc_en_o, 1'h0);
        rd(5'h0c, 8'h04);
        rd(5'h00, 8'h20);
        rd(5'h04, 8'h00);
        per(0, 1, 1);
        done("reset");
        // Locked and unmapped writes change nothing
        wr(5'h0c, 8'($urandom()));
        rd(5'h0c, 8'h04);
        wr(5'h14, 8'($urandom()));
        rd(5'h14, 8'h00);
        wr(5'h10, 8'h01);
        done("protect");
        // Start the resonator, then move the system clock onto it
        wr(5'h04, 8'h08);
        wr(5'h00, 8'h00);
        repeat (4) @(posedge clock_i);
        check(main_osc_en_o, 1'h1);
        check(osc_pin_function_o, 1'h1);
        wr(5'h0c, 8'h00);
        rd(5'h0c, 8'h00);
        done("main start");
        // Every CPU division setting, divide-by-8 last
        for (int i = 0; i < 5; i++) begin
            wr(5'h00, (i == 4) ? 8'h40 : 8'h00);
            wr(5'h04, 8'h08 | 8'(i << 6));
            per(0, 1, (i == 4) ? 8 : (i == 3) ? 16 : 1 << i);
        end
        wr(5'h00, 8'h00);
        per(2, 1, 32);
        per(5, 4, 128);
        done("dividers");
        // Wait mode under each peripheral stop setting, detection off
        for (int f = 0; f < 4; f++) begin
            wr(5'h00, 8'(f << 1));
            wait_mode_i <= 1'h1;
            repeat (4) @(posedge clock_i);
            s = cnt;
            repeat (60) @(posedge clock_i);
            check(cnt[1] != s[1], f == 0);
            check(cnt[3] != s[3], 1'h1);
            check(cnt[4] != s[4], 1'h1);
            wait_mode_i <= 1'h0;
        end
        wr(5'h00, 8'h00);
        done("wait mode");
        // Watchdog ticks only under protection, off afterwards
        for (int p = 0; p < 2; p++) begin
            count_source_protect_i <= 1'(p == 0);
            repeat (4) @(posedge clock_i);
            s = cnt;
            repeat (60) @(posedge clock_i);
            check(cnt[6] != s[6], 1'(p == 0));
        end
        done("watchdog");
        // Low oscillator off on the main clock, then the resonator dies
        wr(5'h04, 8'h18);
        rd(5'h04, 8'h18);
        repeat (4) @(posedge clock_i);
        s = cnt;
        repeat (60) @(posedge clock_i);
        check(cnt[4] != s[4], 1'h0);
        wr(5'h0c, 8'h03);
        rd(5'h0c, 8'h03);
        main_kill <= 1'h1;
        bump(7);
        rd(5'h0c, 8'h0f);
        rd(5'h04, 8'h08);
        check(low_osc_en_o, 1'h1);
        wr(5'h0c, 8'h03);
        rd(5'h0c, 8'h0f);
        wr(5'h04, 8'h18);
        rd(5'h04, 8'h08);
        wr(5'h0c, 8'h05);
        rd(5'h0c, 8'h0d);
        wr(5'h0c, 8'h04);
        rd(5'h0c, 8'h04);
        done("stop detect");
        // Stop mode entry forces divide-by-8
        wr(5'h08, 8'h00);
        stop_mode_i <= 1'h1;
        repeat (4) @(posedge clock_i);
        stop_mode_i <= 1'h0;
        rd(5'h00, 8'h40);
        per(0, 1, 8);
        check(cnt[7], 1);
        done("stop mode");
        finish_test();
    end
endmodule
